/* hw/dcf_pkg.sv */
// Package of constants shared by the programmable-flag FIFO design.
package dcf_pkg;
    // ********************************************************************
    // Geometry
    // ********************************************************************
    localparam int DCF_WIDTH = 18;
    localparam int DCF_DEPTH = 16384;
    localparam int DCF_AW = 14;
    localparam int DCF_OFS_W = 14;
    localparam int DCF_CW = 15;
    // ********************************************************************
    // Reset values and thresholds
    // ********************************************************************
    localparam logic [13:0] DCF_OFS_RST = 14'h007F;
    localparam logic [14:0] DCF_FULL_CNT = 15'h4000;
    localparam logic [14:0] DCF_HALF_CNT = 15'h2001;
    // ********************************************************************
    // Staging FIFO and link timing
    // ********************************************************************
    localparam int DCF_STAGE_DEPTH = 4;
    localparam int DCF_LINK_PERIOD_NS = 200;
endpackage : dcf_pkg

/* hw/dcf_stage_fifo.sv */
// Small synchronous staging FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module dcf_stage_fifo
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // Honest flags: full and empty come straight from the occupancy.
    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write.
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : dcf_stage_fifo
`default_nettype wire

/* hw/dcf_fifo.sv */
// Dual-clock FIFO with programmable flags, sampled on one core clock.
//
// Behaviour
// - Master reset puts the FIFO empty with the empty flag low.
// - After reset the data outputs read low when output drive is enabled.
// - Write enable low and not full stores the input word per write edge.
// - Read enable low and not empty presents the next word per read edge.
// - Outputs float when output drive is high, show output register if low.
// - In a cascade the system ties output drive so only the read-enabled device drives.
// - Full flag low at 16384 words; writes then ignored.
// - Full flag changes only on write clock edges.
// - Empty flag low at zero words; reads then ignored.
// - Empty flag changes only on read clock edges.
// - Reads when empty leave the last valid word on the outputs.
// - Two 14-bit offset registers loaded from the low input bits.
// - Load and write enable low write empty then full offset, cycling.
// - Offset sequence position persists across load going high.
// - Load and read enable low read offsets in the same sequence.
// - Both offsets default to 127.
// - Almost flags low within the empty or full offset of the boundary.
// - Half-full flag low at 8193 words or more.
// - Synchronous mode updates almost-full on write, almost-empty on read.
// - Replay pulse rewinds the read pointer to the first location, only with first_in_chain_n low and after a read since master reset.
// - After replay reads resend old data up to the write pointer.
// - First word is readable the read cycle after empty flag rises.
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int WIDTH = DCF_WIDTH,
    parameter int AW = DCF_AW
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic master_reset,
    input wire logic write_clock,
    input wire logic write_enable_n,
    input wire logic [WIDTH-1:0] write_data,
    input wire logic read_clock,
    input wire logic read_enable_n,
    input wire logic offset_load_n,
    input wire logic replay_pulse,
    input wire logic output_drive_n,
    input wire logic flag_sync_select,
    input wire logic first_in_chain_n,
    output logic [WIDTH-1:0] read_data,
    output logic read_data_oe,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic half_full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n
);
    // ********************************************************************
    // Input synchronisers
    // ********************************************************************
    localparam int NS = 9;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    logic [WIDTH-1:0] d1_q;
    logic [WIDTH-1:0] d2_q;
    logic wclk_q;
    logic rclk_q;
    logic rt_q;

    assign raw = {first_in_chain_n, flag_sync_select, output_drive_n,
        replay_pulse, offset_load_n, read_enable_n, write_enable_n,
        read_clock, write_clock};

    // Every pin passes two flip-flops; the first stage feeds nothing else.
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                begin
                    s1_q[gi] <= 1'b1;
                    s2_q[gi] <= 1'b1;
                end
                else
                begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    // Data word synchroniser, aligned with the control synchronisers.
    always_ff @(posedge ref_clk)
    begin
        d1_q <= write_data;
        d2_q <= d1_q;
    end

    logic wclk_s;
    logic rclk_s;
    logic wen_n;
    logic ren_n;
    logic ld_n;
    logic rt_s;
    logic oe_n;
    logic sync_mode_n;
    logic fl_n;
    logic rs_s;
    logic rs1_q;
    logic rs2_q;
    assign wclk_s = s2_q[0];
    assign rclk_s = s2_q[1];
    assign wen_n = s2_q[2];
    assign ren_n = s2_q[3];
    assign ld_n = s2_q[4];
    assign rt_s = s2_q[5];
    assign oe_n = s2_q[6];
    assign sync_mode_n = s2_q[7];
    assign fl_n = s2_q[8];

    // Master reset is active low and kept out of the generic bank.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end
        else
        begin
            rs1_q <= master_reset;
            rs2_q <= rs1_q;
        end
    end
    assign rs_s = rs2_q;

    // ********************************************************************
    // Edge detection
    // ********************************************************************
    logic wr_edge;
    logic rd_edge;
    logic rt_rise;
    logic rs_low;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wclk_q <= 1'b1;
            rclk_q <= 1'b1;
            rt_q <= 1'b1; // Matches the synchroniser's reset level.
        end
        else
        begin
            wclk_q <= wclk_s;
            rclk_q <= rclk_s;
            rt_q <= rt_s;
        end
    end
    assign wr_edge = wclk_s && !wclk_q;
    assign rd_edge = rclk_s && !rclk_q;
    assign rt_rise = rt_s && !rt_q;
    assign rs_low = !rst_n || !rs_s;

    // ********************************************************************
    // Write staging and storage
    // ********************************************************************
    logic [WIDTH-1:0] mem_q [2**AW];
    logic [AW:0] wp_q;
    logic [AW:0] wq_q;
    logic [AW:0] rp_q;
    logic [AW:0] used;
    logic full;
    logic stg_valid;
    logic stg_ready;
    logic stg_in_ready;
    logic [WIDTH-1:0] stg_data;
    logic wr_take;

    assign used = wp_q - rp_q;
    // Thresholds follow the build's depth rather than the full-size part.
    localparam logic [AW:0] FULL_CNT = {1'b1, {AW{1'b0}}};
    localparam logic [AW:0] HALF_CNT = {2'b01, {(AW-1){1'b0}}} + 1'b1;
    assign full = (used == FULL_CNT);

    // Write requests enter a short staging FIFO so that a stalled store
    // (store full) holds back the word instead of losing it; master reset clears the staging FIFO.
    assign wr_take = wr_edge && !wen_n && ld_n && full_flag_n
        && !rs_low;
    assign stg_ready = !full && !rs_low;

    dcf_stage_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DCF_STAGE_DEPTH)
    ) u_stage (
        .ref_clk(ref_clk),
        .rst_n(rst_n && rs_s),
        .in_data(d2_q),
        .in_valid(wr_take && stg_in_ready),
        .in_ready(stg_in_ready),
        .out_data(stg_data),
        .out_valid(stg_valid),
        .out_ready(stg_ready)
    );

    // Array write; the index wraps naturally at the last location.
    always_ff @(posedge ref_clk)
    begin
        if (stg_valid && stg_ready)
        begin
            mem_q[wp_q[AW-1:0]] <= stg_data;
        end
    end

    // Write pointer.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            wp_q <= '0;
        end
        else if (stg_valid && stg_ready)
        begin
            wp_q <= wp_q + 1'b1;
        end
    end

    // Words accepted at the pins, counted before the staging FIFO so that
    // the full flag closes on the very edge that fills the store.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            wq_q <= '0;
        end
        else if (wr_take)
        begin
            wq_q <= wq_q + 1'b1;
        end
    end

    // ********************************************************************
    // Read side
    // ********************************************************************
    logic rd_take;
    logic ofs_rd;
    logic [WIDTH-1:0] out_q;
    logic [DCF_OFS_W-1:0] ae_ofs_q;
    logic [DCF_OFS_W-1:0] af_ofs_q;
    logic wsel_q;
    logic rsel_q;
    logic seen_read_q;

    assign rd_take = rd_edge && !ren_n && ld_n && empty_flag_n
        && !rs_low;
    assign ofs_rd = rd_edge && !ren_n && !ld_n && !rs_low;

    // Read pointer, including the replay rewind to location zero.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            rp_q <= '0;
        end
        else if (rt_rise && seen_read_q && !fl_n)
        begin
            // Rewind to location zero of the lap that leaves the distance
            // equal to the words written; a write pointer on location zero
            // means a whole depth, so the lap bit flips.
            rp_q <= {wp_q[AW] ^ (wp_q[AW-1:0] == '0),
                {AW{1'b0}}};
        end
        else if (rd_take)
        begin
            rp_q <= rp_q + 1'b1;
        end
    end

    // Tracks whether a read has happened since master reset.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            seen_read_q <= 1'b0;
        end
        else if (rd_take)
        begin
            seen_read_q <= 1'b1;
        end
    end

    // Output register: FIFO word, offset value, or held last word.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            out_q <= '0;
        end
        else if (rd_take)
        begin
            out_q <= mem_q[rp_q[AW-1:0]];
        end
        else if (ofs_rd)
        begin
            out_q <= WIDTH'(rsel_q ? af_ofs_q : ae_ofs_q);
        end
    end // Otherwise the last word stays visible.

    // Output drive: enabled only when output_drive_n is low. In a cascade
    // the system ties it per device so only the read-enabled one drives.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            read_data <= '0;
            read_data_oe <= 1'b0;
        end
        else
        begin
            read_data <= out_q;
            read_data_oe <= !oe_n;
        end
    end

    // ********************************************************************
    // Offset registers
    // ********************************************************************
    // Write sequence pointer survives load going high.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            ae_ofs_q <= DCF_OFS_RST;
            af_ofs_q <= DCF_OFS_RST;
            wsel_q <= 1'b0;
        end
        else if (wr_edge && !ld_n && !wen_n)
        begin
            if (wsel_q)
            begin
                af_ofs_q <= d2_q[DCF_OFS_W-1:0];
            end
            else
            begin
                ae_ofs_q <= d2_q[DCF_OFS_W-1:0];
            end
            wsel_q <= !wsel_q;
        end
    end

    // Read sequence pointer, same alternation.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            rsel_q <= 1'b0;
        end
        else if (ofs_rd)
        begin
            rsel_q <= !rsel_q;
        end
    end

    // ********************************************************************
    // Flags
    // ********************************************************************
    logic [AW:0] wcnt;
    logic [AW:0] rcnt;
    logic ae_now;
    logic af_now;
    // Counts as they stand after this edge's own write or read, so a flag
    // turns on the very edge that reaches its boundary.
    assign wcnt = wq_q - rp_q + (AW+1)'(wr_take);
    assign rcnt = used - (AW+1)'(rd_take);
    // Compared at 32 bits: a 14-bit offset may exceed a small build's depth.
    assign ae_now = (32'(rcnt) <= 32'(ae_ofs_q));
    assign af_now = (32'(wcnt) + 32'(af_ofs_q) >= 32'(2 ** AW));

    // Full flag follows the write clock only.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            full_flag_n <= 1'b1;
        end
        else if (wr_edge)
        begin
            full_flag_n <= (wcnt != FULL_CNT);
        end
    end

    // Empty flag follows the read clock only; one read edge of lag means
    // the first word is fetched on the edge after the flag rises.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            empty_flag_n <= 1'b0;
        end
        else if (rd_edge)
        begin
            empty_flag_n <= (rcnt != '0);
        end
    end

    // Almost-full: write edges in sync mode, else every core cycle.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            almost_full_flag_n <= 1'b1;
        end
        else if (wr_edge || sync_mode_n)
        begin
            almost_full_flag_n <= !af_now;
        end
    end

    // Almost-empty: read edges in sync mode, else every core cycle.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            almost_empty_flag_n <= 1'b0;
        end
        else if (rd_edge || sync_mode_n)
        begin
            almost_empty_flag_n <= !ae_now;
        end
    end

    // Half-full tracks the occupancy directly.
    always_ff @(posedge ref_clk)
    begin
        if (rs_low)
        begin
            half_full_flag_n <= 1'b1;
        end
        else
        begin
            half_full_flag_n <= !(used >= HALF_CNT);
        end
    end
endmodule : dcf_fifo
`default_nettype wire

/* tb/dcf_fifo_assertions.sv */
// Port checker for the programmable-flag FIFO.
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo_checker
    import dcf_pkg::*;
#(
    parameter int WIDTH = DCF_WIDTH
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic master_reset,
    input wire logic write_clock,
    input wire logic read_clock,
    input wire logic offset_load_n,
    input wire logic replay_pulse,
    input wire logic output_drive_n,
    input wire logic flag_sync_select,
    input wire logic [WIDTH-1:0] read_data,
    input wire logic read_data_oe,
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic half_full_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic almost_full_flag_n
);
    logic wc_q;
    logic rc_q;
    logic [3:0] wa_q;
    logic [3:0] ra_q;
    logic [3:0] qa_q;
    // Ages since the last link edge or disturbance, held at 15.
    // Reset clears them so that nothing fires straight after reset.
    always_ff @(posedge ref_clk)
    begin
        wc_q <= write_clock;
        rc_q <= read_clock;
        if (!rst_n || (write_clock && !wc_q))
            wa_q <= 4'h0;
        else if (wa_q != 4'hF)
            wa_q <= wa_q + 4'h1;
        if (!rst_n || (read_clock && !rc_q))
            ra_q <= 4'h0;
        else if (ra_q != 4'hF)
            ra_q <= ra_q + 4'h1;
        if (!rst_n || !master_reset || !offset_load_n || replay_pulse)
            qa_q <= 4'h0;
        else if (qa_q != 4'hF)
            qa_q <= qa_q + 4'h1;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    chk_reset_flags: assert property (
        !master_reset [*4] |-> !empty_flag_n && full_flag_n
        && half_full_flag_n && !almost_empty_flag_n && almost_full_flag_n)
        else $error("flags wrong under master reset");
    chk_reset_word: assert property (
        !master_reset [*5] |-> read_data == '0)
        else $error("output word not low under master reset");
    chk_drive_off: assert property (
        output_drive_n [*4] |-> !read_data_oe)
        else $error("outputs driven while drive is off");
    chk_full_edge: assert property (
        $changed(full_flag_n) && qa_q > 4'h8 |-> wa_q < 4'h8)
        else $error("full flag moved away from a write edge");
    chk_empty_edge: assert property (
        $changed(empty_flag_n) && qa_q > 4'h8 |-> ra_q < 4'h8)
        else $error("empty flag moved away from a read edge");
    chk_afull_edge: assert property (
        !flag_sync_select && $changed(almost_full_flag_n) && qa_q > 4'h8
        |-> wa_q < 4'h8)
        else $error("almost full flag moved away from a write edge");
    chk_empty_hold: assert property (
        !empty_flag_n && !$past(empty_flag_n, 4) && qa_q > 4'h8
        |-> $stable(read_data))
        else $error("output word changed while empty");
    chk_full_half: assert property (
        $fell(full_flag_n) |-> ##[0:2] !half_full_flag_n)
        else $error("full without half full");
    chk_empty_almost: assert property (
        $fell(empty_flag_n) |-> ##[0:2] !almost_empty_flag_n)
        else $error("empty without almost empty");
endmodule : dcf_fifo_checker
bind dcf_fifo dcf_fifo_checker #(.WIDTH(WIDTH)) i_dcf_fifo_checker (.*);
`default_nettype wire

/* tb/dcf_link_model.sv */
// Writer and reader that clock single words across the link pins.
`timescale 1ns/100ps
`default_nettype none
module dcf_link_model
    import dcf_pkg::*;
(
    input wire logic ref_clk,
    output logic write_clock,
    output logic write_enable_n,
    output logic [DCF_WIDTH-1:0] write_data,
    output logic read_clock,
    output logic read_enable_n
);
    // Link clocks rest low between words and enables rest inactive.
    initial
    begin
        write_clock = 1'b0;
        write_enable_n = 1'b1;
        write_data = '0;
        read_clock = 1'b0;
        read_enable_n = 1'b1;
    end
    // Controls are held four core cycles on both sides of the edge.
    task automatic push(input logic [DCF_WIDTH-1:0] d, input logic en_n);
        @(posedge ref_clk);
        write_enable_n <= en_n;
        write_data <= d;
        repeat (4) @(posedge ref_clk);
        write_clock <= 1'b1;
        repeat (4) @(posedge ref_clk);
        write_clock <= 1'b0;
        write_enable_n <= 1'b1;
        write_data <= ~d; // Stale data is inverted so it never looks valid.
        repeat (4) @(posedge ref_clk);
    endtask : push
    // One read beat; the word has settled when the task returns.
    task automatic pull(input logic en_n);
        @(posedge ref_clk);
        read_enable_n <= en_n;
        repeat (4) @(posedge ref_clk);
        read_clock <= 1'b1;
        repeat (4) @(posedge ref_clk);
        read_clock <= 1'b0;
        read_enable_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask : pull
endmodule : dcf_link_model
`default_nettype wire

/* tb/dual_clock_fifo_programmable_flags_test.sv */
// Self-checking bench for the programmable-flag FIFO.
`timescale 1ns/100ps
`default_nettype none
module dual_clock_fifo_programmable_flags_test
    import dcf_pkg::*;
;
    localparam int N = 16;
    logic ref_clk = 1'b0;
    logic rst_n;
    logic master_reset;
    logic offset_load_n;
    logic replay_pulse;
    logic output_drive_n;
    logic flag_sync_select;
    logic first_in_chain_n;
    logic write_clock;
    logic write_enable_n;
    logic [17:0] write_data;
    logic read_clock;
    logic read_enable_n;
    logic [17:0] read_data;
    logic read_data_oe;
    logic empty_flag_n;
    logic full_flag_n;
    logic half_full_flag_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
    logic [4:0] flg;
    int miscompares = 0;
    int n_compared = 0;
    // A 16-word build keeps the fill and drain short.
    dcf_fifo #(.AW(4)) i_dcf_fifo (.*);
    dcf_link_model i_dcf_link_model (.*);
    assign flg = {empty_flag_n, full_flag_n, half_full_flag_n,
        almost_empty_flag_n, almost_full_flag_n};
    always #12.5 ref_clk = ~ref_clk;
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [17:0] seen,
        input logic [17:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    function automatic logic [17:0] wd(input int i);
        return 18'h25A00 + 18'(i);
    endfunction : wd
    // Link traffic stays quiet while the device reset is low.
    task automatic mreset();
        master_reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check("reset flags", 18'(flg), 18'h0D);
        check("reset word", read_data, 18'h0);
        master_reset <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask : mreset
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_offsets();
        offset_load_n <= 1'b0;
        i_dcf_link_model.pull(1'b0);
        check("empty ofs", read_data, 18'h7F);
        i_dcf_link_model.pull(1'b0);
        check("full ofs", read_data, 18'h7F);
        i_dcf_link_model.push(18'h5, 1'b0);
        i_dcf_link_model.push(18'h3, 1'b0);
        offset_load_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        offset_load_n <= 1'b0;
        i_dcf_link_model.push(18'h30002, 1'b0);
        i_dcf_link_model.push(18'h9, 1'b1);
        i_dcf_link_model.pull(1'b0);
        check("empty ofs", read_data, 18'h2);
        i_dcf_link_model.pull(1'b0);
        check("full ofs", read_data, 18'h3);
        offset_load_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask : t_offsets
    // Fill to the brim, then offer one word too many.
    task automatic t_fill();
        for (int i = 0; i < N; i++)
        begin
            i_dcf_link_model.push(wd(i), 1'b0);
            check("full", 18'(full_flag_n), 18'(i != N-1));
            check("half", 18'(half_full_flag_n), 18'(i < N/2));
            check("afull", 18'(almost_full_flag_n), 18'(i < N-4));
        end
        i_dcf_link_model.push(18'h2AAAA, 1'b0);
    endtask : t_fill
    // The first edge only lifts the empty flag; words follow.
    task automatic t_drain();
        i_dcf_link_model.pull(1'b0);
        check("first edge flag", 18'(empty_flag_n), 18'h1);
        check("first edge word", read_data, 18'h3);
        for (int i = 0; i < N; i++)
        begin
            i_dcf_link_model.pull(1'b0);
            check("word", read_data, wd(i));
            check("empty", 18'(empty_flag_n), 18'(i != N-1));
            check("aempty", 18'(almost_empty_flag_n), 18'(i < N-3));
        end
        i_dcf_link_model.pull(1'b0);
        check("last word", read_data, wd(N-1));
    endtask : t_drain
    // Clocks stand still around the replay pulse.
    task automatic t_replay();
        mreset();
        for (int i = 0; i < 3; i++)
            i_dcf_link_model.push(wd(20+i), 1'b0);
        i_dcf_link_model.pull(1'b0);
        i_dcf_link_model.pull(1'b0);
        check("pre replay", read_data, wd(20));
        replay_pulse <= 1'b1;
        repeat (4) @(posedge ref_clk);
        replay_pulse <= 1'b0;
        repeat (8) @(posedge ref_clk);
        i_dcf_link_model.push(wd(23), 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            i_dcf_link_model.pull(1'b0);
            check("replayed", read_data, wd(20+i));
        end
    endtask : t_replay
    // Replay refused off the first device; almost flags running free.
    task automatic t_modes();
        first_in_chain_n <= 1'b1;
        offset_load_n <= 1'b0;
        i_dcf_link_model.push(18'h1, 1'b0);
        offset_load_n <= 1'b1;
        flag_sync_select <= 1'b1;
        i_dcf_link_model.push(wd(30), 1'b0);
        i_dcf_link_model.push(wd(31), 1'b0);
        check("async ae flag", 18'(almost_empty_flag_n), 18'h1);
        flag_sync_select <= 1'b0;
        i_dcf_link_model.pull(1'b0);
        i_dcf_link_model.pull(1'b0);
        replay_pulse <= 1'b1;
        repeat (4) @(posedge ref_clk);
        replay_pulse <= 1'b0;
        repeat (8) @(posedge ref_clk);
        i_dcf_link_model.pull(1'b0);
        check("no replay", read_data, wd(31));
        first_in_chain_n <= 1'b0;
    endtask : t_modes
    task automatic t_drive();
        output_drive_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("drive off", 18'(read_data_oe), 18'h0);
        output_drive_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("drive on", 18'(read_data_oe), 18'h1);
    endtask : t_drive
    initial
    begin
        rst_n <= 1'b0;
        master_reset <= 1'b1;
        offset_load_n <= 1'b1;
        replay_pulse <= 1'b0;
        output_drive_n <= 1'b0;
        flag_sync_select <= 1'b0;
        first_in_chain_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        mreset();
        t_offsets();
        t_fill();
        t_drain();
        t_replay();
        t_modes();
        t_drive();
        tally_and_finish();
    end
    // Watchdog: the run needs about a fifth of this span.
    initial
    begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule : dual_clock_fifo_programmable_flags_test
`default_nettype wire
